// ### src/acquisition_trigger_control.sv
`timescale 1ns/100ps
module acquisition_trigger_control
  import acq_trigger_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               clkEn,
  input  wire logic               mode_select_low,
  input  wire logic               mode_select_high,
  input  wire logic               softwareModeSel,
  input  wire logic               level_trigger_input,
  input  wire logic               syncTriggerInput,
  input  wire logic               adcClockTick,
  input  wire logic [INTEG_W-1:0] integPeriod,
  output logic                    integrating,
  output logic                    scanDone,
  output logic [INTEG_W-1:0]      scanLength,
  output trig_mode_t              activeMode
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic selLowS;
  logic selHighS;
  logic levelTrigS;
  logic syncTrigS;

  two_stage_sync uSelLow (
    .clk     (clk),
    .reset_n (reset_n),
    .clkEn   (clkEn),
    .asyncIn (mode_select_low),
    .syncOut (selLowS)
  );
  two_stage_sync uSelHigh (
    .clk     (clk),
    .reset_n (reset_n),
    .clkEn   (clkEn),
    .asyncIn (mode_select_high),
    .syncOut (selHighS)
  );
  two_stage_sync uLevel (
    .clk     (clk),
    .reset_n (reset_n),
    .clkEn   (clkEn),
    .asyncIn (level_trigger_input),
    .syncOut (levelTrigS)
  );
  two_stage_sync uSyncTrig (
    .clk     (clk),
    .reset_n (reset_n),
    .clkEn   (clkEn),
    .asyncIn (syncTriggerInput),
    .syncOut (syncTrigS)
  );

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  function automatic trig_mode_t decodeMode(input logic hi,
                                            input logic lo,
                                            input logic sw);
    if (hi && lo) begin
      decodeMode = MODE_HARDWARE;
    end else if (hi) begin
      decodeMode = MODE_SYNC;
    end else if (sw) begin
      decodeMode = MODE_SOFTWARE;
    end else begin
      decodeMode = MODE_NORMAL;
    end
  endfunction

  trig_mode_t modeNow;
  trig_mode_t mode_r;

  assign modeNow = decodeMode(selHighS, selLowS, softwareModeSel);

  // registered so a mode change is seen one cycle late, except by the scan state machine's modeNow compare
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= MODE_NORMAL;
    end else if (clkEn) begin
      mode_r <= modeNow;
    end
  end

  assign activeMode = mode_r;

  // ----------------------------------------------------------------
  // sync edge detect (reads second stage only)
  // ----------------------------------------------------------------
  logic syncPrev_r;
  logic syncEdge;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncPrev_r <= 1'b0;
    end else if (clkEn) begin
      syncPrev_r <= syncTrigS;
    end
  end

  // the trigger edge is the integration clock
  assign syncEdge = syncTrigS && !syncPrev_r;

  // ----------------------------------------------------------------
  // integration timer, counts converter ticks
  // ----------------------------------------------------------------
  logic [INTEG_W-1:0] tickCnt_r;
  logic               periodEnd;
  logic [INTEG_W-1:0] periodGoal;

  // a zero period is treated as one tick, so it ends on every converter tick
  assign periodGoal = (integPeriod == INTEG_RST) ? INTEG_ONE : integPeriod;
  assign periodEnd  = adcClockTick && (tickCnt_r + INTEG_ONE >= periodGoal);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tickCnt_r <= INTEG_RST;
    end else if (clkEn) begin
      if (mode_r == MODE_SYNC || mode_r == MODE_HARDWARE) begin
        tickCnt_r <= INTEG_RST;
      end else if (periodEnd) begin
        tickCnt_r <= INTEG_RST;
      end else if (adcClockTick) begin
        tickCnt_r <= tickCnt_r + INTEG_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // scan state and delivery
  // ----------------------------------------------------------------
  scan_state_t        state_r;
  logic [INTEG_W-1:0] lenCnt_r;
  logic               deliver;
  logic               freeRun;

  assign freeRun = (mode_r == MODE_NORMAL) || (mode_r == MODE_SOFTWARE);

  // delivery decision per mode
  always_comb begin
    case (mode_r)
      MODE_NORMAL:   deliver = periodEnd;
      // level high at period end delivers
      MODE_SOFTWARE: deliver = periodEnd && levelTrigS;
      MODE_SYNC:     deliver = syncEdge && (state_r == ST_INTEGRATE);
      default:       deliver = 1'b0;
    endcase
  end

  // scan state machine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
    end else if (clkEn) begin
      case (state_r)
        ST_IDLE: begin
          if (freeRun) begin
            state_r <= ST_INTEGRATE;
          end else if (mode_r == MODE_SYNC && syncEdge) begin
            state_r <= ST_INTEGRATE;
          end
        end
        ST_INTEGRATE: begin
          // leaving a mode drops back to idle
          if (!freeRun && mode_r != MODE_SYNC) begin
            state_r <= ST_IDLE;
          end else if (modeNow != mode_r) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // scan length counter: restarts on every boundary
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lenCnt_r <= INTEG_RST;
    end else if (clkEn) begin
      if (state_r != ST_INTEGRATE) begin
        lenCnt_r <= INTEG_ONE;
      end else if (deliver || (freeRun && periodEnd)) begin
        lenCnt_r <= INTEG_ONE;
      end else if (lenCnt_r != {INTEG_W{1'b1}}) begin
        lenCnt_r <= lenCnt_r + INTEG_ONE;
      end
    end
  end

  // delivery outputs registered
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scanDone   <= 1'b0;
      scanLength <= INTEG_RST;
    end else if (clkEn) begin
      scanDone <= deliver;
      // length of sync scan is edge interval
      if (deliver) begin
        scanLength <= lenCnt_r;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      integrating <= 1'b0;
    end else if (clkEn) begin
      integrating <= (state_r == ST_INTEGRATE);
    end
  end

endmodule

// ### src/acq_trigger_pkg.sv
package acq_trigger_pkg;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int          INTEG_W        = 24;
  localparam int          SYNC_STAGES    = 2;
  localparam logic [23:0] INTEG_RST      = 24'h000000;
  localparam logic [23:0] INTEG_ONE      = 24'h000001;
  localparam logic [1:0]  SYNC_RST       = 2'h0;

  // ----------------------------------------------------------------
  // modes and scan states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_SOFTWARE,
    MODE_SYNC,
    MODE_HARDWARE
  } trig_mode_t;

  typedef enum {
    ST_IDLE,
    ST_INTEGRATE
  } scan_state_t;

endpackage

// ### src/two_stage_sync.sv
`timescale 1ns/100ps
// two flip-flop synchroniser for one asynchronous level
module two_stage_sync
  import acq_trigger_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic clkEn,
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic [1:0] chain_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chain_r <= SYNC_RST;
    end else if (clkEn) begin
      chain_r <= {chain_r[0], asyncIn};
    end
  end

  assign syncOut = chain_r[1];

endmodule

// ### bench/trig_source.sv
`timescale 1ns/100ps
// far-side triggering device, same clock for a repeatable edge spacing
module trig_source (
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic [7:0] period,
  output logic            syncTrig
);
  logic [7:0] edgeCnt_r = 8'h00;
  initial syncTrig = 1'b0;
  always @(posedge clk) begin
    edgeCnt_r <= (!run || edgeCnt_r == period - 8'h01) ? 8'h00
                 : edgeCnt_r + 8'h01;
    syncTrig <= run && edgeCnt_r < (period >> 1);
  end
endmodule

// ### bench/acq_trigger_checker_sva.sv
`timescale 1ns/100ps
module acq_trigger_checker
  import acq_trigger_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic mode_select_low,
  input wire logic mode_select_high,
  input wire logic softwareModeSel,
  input wire logic level_trigger_input,
  input wire logic syncTriggerInput,
  input wire logic integrating,
  input wire logic scanDone,
  input trig_mode_t activeMode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // pins settled long enough to pass both sync stages
  sequence pinsHeld;
    ($stable({mode_select_high, mode_select_low, softwareModeSel})
     && clkEn)[*4];
  endsequence
  sequence syncEdge;
    activeMode == MODE_SYNC && integrating && $rose(syncTriggerInput);
  endsequence
  AST_MODE_DECODE: assert property (pinsHeld |-> activeMode ==
    (mode_select_high ? (mode_select_low ? MODE_HARDWARE : MODE_SYNC)
     : (softwareModeSel ? MODE_SOFTWARE : MODE_NORMAL)))
    else $error("mode decode wrong");
  AST_HW_IDLE: assert property (
    (activeMode == MODE_HARDWARE)[*3] |-> !integrating && !scanDone)
    else $error("busy in hardware mode");
  AST_SYNC_IDLE: assert property (
    (activeMode == MODE_SYNC && !integrating && !syncTriggerInput)[*5]
    |=> !integrating) else $error("sync scan without edge");
  AST_SYNC_DELIVER: assert property (
    syncEdge |-> ##1 !scanDone[*2] ##[1:3] scanDone)
    else $error("sync delivery timing");
  AST_SYNC_RESTART: assert property (
    scanDone && activeMode == MODE_SYNC |-> integrating)
    else $error("no new scan after delivery");
  AST_FIRST_EDGE: assert property (
    $rose(integrating) && activeMode == MODE_SYNC |-> !scanDone[*3])
    else $error("first edge delivered");
  AST_SW_LOW: assert property (
    (activeMode == MODE_SOFTWARE && !level_trigger_input)[*8]
    |-> !scanDone) else $error("delivery with trigger low");
  AST_NORMAL_RUN: assert property (
    (activeMode == MODE_NORMAL && clkEn)[*8]
    |-> integrating || $past(integrating)) else $error("normal stalled");
endmodule
bind acquisition_trigger_control acq_trigger_checker acq_trigger_checker_i (
  .clk(clk), .reset_n(reset_n), .clkEn(clkEn),
  .mode_select_low(mode_select_low), .mode_select_high(mode_select_high),
  .softwareModeSel(softwareModeSel),
  .level_trigger_input(level_trigger_input),
  .syncTriggerInput(syncTriggerInput), .integrating(integrating),
  .scanDone(scanDone), .activeMode(activeMode)
);

// ### bench/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import acq_trigger_pkg::*;
;
  logic               clk = 1'b0, resetN = 1'b0, selLo = 1'b0;
  logic               selHi = 1'b0, swSel = 1'b0, lvlTrig = 1'b0;
  logic               tick = 1'b0, trigRun = 1'b0, syncTrig, clkEn = 1'b1;
  logic [1:0]         tickMode = 2'h1;
  logic [7:0]         trigPer = 8'h10;
  logic [INTEG_W-1:0] period, scanLength, expQ[$];
  logic               integrating, scanDone;
  trig_mode_t         activeMode;
  int                 seed = 32'h6CFF8940, nFail = 0, nChecks = 0, p;
  // clock and converter ticks: every cycle, every other cycle or none
  always #2 clk = ~clk;
  always @(posedge clk) tick <= tickMode[0] | (tickMode[1] & ~tick);
  acquisition_trigger_control acquisition_trigger_control_i (
    .clk(clk), .reset_n(resetN), .clkEn(clkEn),
    .mode_select_low(selLo), .mode_select_high(selHi),
    .softwareModeSel(swSel), .level_trigger_input(lvlTrig),
    .syncTriggerInput(syncTrig), .adcClockTick(tick),
    .integPeriod(period), .integrating(integrating),
    .scanDone(scanDone), .scanLength(scanLength), .activeMode(activeMode)
  );
  trig_source trig_source_i (
    .clk(clk), .run(trigRun), .period(trigPer), .syncTrig(syncTrig)
  );
  task automatic chkLen(input logic [INTEG_W-1:0] got, exp);
    nChecks++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value at %0t: length %0d not %0d", $time, got, exp);
    end
  endtask
  task automatic chkBit(input logic got, exp);
    nChecks++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value at %0t: flag %b not %b", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (nFail == 0 && nChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // wait for one delivery, or for all notes to be used up
  task automatic waitEv(input bit drain);
    int n;
    n = 0;
    while ((drain ? expQ.size() > 0 : scanDone !== 1'b1) && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n == 3000) begin
      nFail++;
      give_verdict();
    end
    @(negedge clk);
  endtask
  // monitor: oldest note against each delivery; extra ones are ignored
  always @(negedge clk)
    if (scanDone === 1'b1 && expQ.size() > 0)
      chkLen(scanLength, expQ.pop_front());
  initial begin
    p = 3 + ($random(seed) & 7);
    period <= 24'(p);
    repeat (8) @(posedge clk);
    resetN <= 1'b1;
    waitEv(0);
    // enable low: a period shorter than the hold must not deliver
    @(posedge clk);
    clkEn <= 1'b0;
    repeat (20) begin
      @(negedge clk);
      chkBit(scanDone, 1'b0);
    end
    @(posedge clk);
    clkEn <= 1'b1;
    repeat (3) expQ.push_back(24'(p));
    waitEv(1);
    @(posedge clk);
    swSel <= 1'b1;
    lvlTrig <= 1'b1;
    tickMode <= 2'h2;
    waitEv(0);
    waitEv(0);
    repeat (3) expQ.push_back(24'(2 * p));
    waitEv(1);
    @(posedge clk);
    lvlTrig <= 1'b0;
    repeat (6 * p) @(posedge clk);
    expQ.push_back(24'(2 * p));
    lvlTrig <= 1'b1;
    waitEv(1);
    @(posedge clk);
    lvlTrig <= 1'b0;
    repeat (30) @(posedge clk);
    selHi <= 1'b1;
    tickMode <= 2'h0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    chkBit(integrating, 1'b0);
    p = 10 + ($random(seed) & 31);
    @(posedge clk);
    trigPer <= 8'(p);
    trigRun <= 1'b1;
    repeat (3) expQ.push_back(24'(p));
    waitEv(1);
    @(posedge clk);
    trigRun <= 1'b0;
    selLo <= 1'b1;
    repeat (12) @(posedge clk);
    trigRun <= 1'b1;
    repeat (3 * p) @(posedge clk);
    @(negedge clk);
    chkBit(integrating, 1'b0);
    give_verdict();
  end
endmodule
